// ===== rtl/ccu_pkg.sv
// Purpose: shared constants of the capture/compare channel
// Assumes: apb slave with 32-bit data, one word per register
// Notes:   mode codes, register offsets, field positions and reset values
//
// Overview of operation
// - capture copies whole 16-bit timer count
// - four capture events: fall, rise, 4th, 16th
// - capture codes 0100, 0101, 0110, 0111
// - capture sets flag; only software clears it
// - newer capture overwrites unread older value
// - capture watches pin level, even when output
// - capture only with synchronous timer time base
// - timer choice comes from third timer control
// - prescaler cleared when off or capture left
// - prescaler switch keeps count; software zeroes first
// - compare value against timer, flag on equal
// - match drives pin high, low, toggle, or port
// - compare codes 0010 toggle, 1000 high, 1001 low
// - zero control forces compare latch low
// - compare only with synchronous timer time base
// - code 1010 only sets flag, pin stays port
// - code 1011 emits special event, sets flag
// - special event resets the assigned timer count
// - second enhanced channel event starts conversion
// - code 0000 disables channel, clears prescaler and compare latch; flag and value keep
`default_nettype none

package ccu_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_CONTROL    = 8'h00;
    localparam logic [7:0] OFS_VALUE_LOW  = 8'h04;
    localparam logic [7:0] OFS_VALUE_HIGH = 8'h08;
    localparam logic [7:0] OFS_T3_CONTROL = 8'h0c;
    localparam logic [7:0] OFS_STATUS     = 8'h10;

    // reset values
    localparam logic [7:0] RST_CONTROL    = 8'h00;
    localparam logic [7:0] RST_VALUE      = 8'h00;
    localparam logic [7:0] RST_T3_CONTROL = 8'h00;

    // control register fields
    localparam int         CTL_MODE_LSB   = 0;
    localparam int         CTL_DUTY_LSB   = 4;
    localparam logic [7:0] CTL_WR_MASK    = 8'h3f;

    // third timer control: timer assignment bits
    localparam int         T3_ASSIGN_LOWER = 3;
    localparam int         T3_ASSIGN_UPPER = 6;

    // status register fields
    localparam int         STS_FLAG       = 0;
    localparam int         STS_ENABLE     = 1;
    localparam int         STS_COMPARE    = 2;

    // mode field codes
    localparam logic [3:0] MODE_OFF       = 4'h0;
    localparam logic [3:0] MODE_CMP_TOG   = 4'h2;
    localparam logic [3:0] MODE_CAP_FALL  = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE  = 4'h5;
    localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
    localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
    localparam logic [3:0] MODE_CMP_HIGH  = 4'h8;
    localparam logic [3:0] MODE_CMP_LOW   = 4'h9;
    localparam logic [3:0] MODE_CMP_SOFT  = 4'ha;
    localparam logic [3:0] MODE_CMP_EVENT = 4'hb;

    // prescaler terminal counts
    localparam logic [3:0] PRESC_LAST4    = 4'h3;
    localparam logic [3:0] PRESC_LAST16   = 4'hf;

endpackage : ccu_pkg

`default_nettype wire

// ===== rtl/capture_edge_prescaler.sv
// Purpose: pin synchroniser, edge detector and capture prescaler
// Assumes: mode is the channel mode field, stable for several cycles
// Notes:   capture_pulse is one cycle long, one per qualifying event
`timescale 1ns/1ns
`default_nettype none

module capture_edge_prescaler
    import ccu_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       pin_level,
    input  wire logic [3:0] mode,
    output var  logic       capture_pulse
);

    logic       sync1_q;
    logic       sync2_q;
    logic       prev_q;
    logic [3:0] presc_q;
    logic [3:0] presc_d;
    wire        rise_w;
    wire        fall_w;
    wire        capture_mode_w;
    wire        fire_w;

    // two-flop synchroniser, then a history flop for edges
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q  <= 1'b0;
        end else begin
            sync1_q <= pin_level;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    assign rise_w         = sync2_q & ~prev_q;
    assign fall_w         = ~sync2_q & prev_q;
    assign capture_mode_w = (mode[3:2] == 2'b01);

    // event qualification per capture code
    assign fire_w = (mode == MODE_CAP_FALL)   ? fall_w :
                    (mode == MODE_CAP_RISE)   ? rise_w :
                    (mode == MODE_CAP_RISE4)  ? rise_w & (presc_q[1:0] == PRESC_LAST4[1:0]) :
                    (mode == MODE_CAP_RISE16) ? rise_w & (presc_q == PRESC_LAST16) :
                    1'b0;

    // count rising edges; leaving capture clears, switching keeps
    assign presc_d = !capture_mode_w ? 4'h0 :
                     rise_w ? presc_q + 4'h1 : presc_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            presc_q       <= 4'h0;
            capture_pulse <= 1'b0;
        end else begin
            presc_q       <= presc_d;
            capture_pulse <= fire_w & capture_mode_w;
        end
    end

endmodule : capture_edge_prescaler

`default_nettype wire

// ===== rtl/capture_compare_unit.sv
// Purpose: capture/compare channel with apb register access
// Assumes: timer counts and their sync indications are ref_clk synchronous
// Notes:   pin direction lives outside; this block gives the pin value
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ns
`default_nettype none

module capture_compare_unit
    import ccu_pkg::*;
#(
    parameter int CHANNEL_INDEX = 4
)
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output logic             pready,
    output var  logic        pslverr,
    // time bases
    input  wire logic [15:0] first_time_base,
    input  wire logic [15:0] second_time_base,
    input  wire logic        first_timer_sync_ok,
    input  wire logic        second_timer_sync_ok,
    output var  logic        first_timer_reset,
    output var  logic        second_timer_reset,
    output var  logic [7:0]  third_timer_control,
    // pin side
    input  wire logic        channel_pin_in,
    input  wire logic        port_latch_in,
    output var  logic        channel_pin_out,
    output var  logic        compare_owns_pin,
    // system side
    input  wire logic        adc_enabled,
    output var  logic        special_event_trigger,
    output var  logic        adc_start,
    output var  logic        channel_irq_request
);

    // register state
    logic [7:0]  control_q;
    logic [7:0]  value_low_q;
    logic [7:0]  value_high_q;
    logic [7:0]  t3_control_q;
    logic        irq_flag_q;
    logic        irq_enable_q;
    logic        compare_latch_q;
    logic        match_prev_q;

    // next values
    logic [7:0]  control_d;
    logic [7:0]  value_low_d;
    logic [7:0]  value_high_d;
    logic [7:0]  t3_control_d;
    logic        irq_flag_d;
    logic        irq_enable_d;
    logic        compare_latch_d;

    // bus decode
    wire         setup_w;
    wire         wr_w;
    wire         hit_control_w;
    wire         hit_low_w;
    wire         hit_high_w;
    wire         hit_t3_w;
    wire         hit_status_w;
    wire         mapped_w;
    wire [31:0]  rd_word_w;

    // mode decode
    wire [3:0]   mode_w;
    wire         capture_mode_w;
    wire         compare_mode_w;
    wire         compare_pin_mode_w;
    wire         event_mode_w;

    // time base selection
    wire [1:0]   assign_w;
    wire         use_first_w;
    wire [15:0]  timer_w;
    wire         timer_sync_w;

    // events
    wire         capture_pulse_w;
    wire         capture_w;
    wire [15:0]  value_w;
    wire         equal_w;
    wire         match_w;
    wire         event_w;
    wire         flag_set_w;
    wire         flag_clr_w;
    wire         pin_next_w;

    // apb phase qualifiers; writes land in the access phase
    assign setup_w = psel & ~penable;
    assign wr_w    = psel & penable & pwrite;
    assign pready  = psel & penable;

    // address decode
    assign hit_control_w = (paddr == OFS_CONTROL);
    assign hit_low_w     = (paddr == OFS_VALUE_LOW);
    assign hit_high_w    = (paddr == OFS_VALUE_HIGH);
    assign hit_t3_w      = (paddr == OFS_T3_CONTROL);
    assign hit_status_w  = (paddr == OFS_STATUS);
    assign mapped_w      = hit_control_w | hit_low_w | hit_high_w | hit_t3_w | hit_status_w;

    // read selection; unmapped and reserved bits read zero
    assign rd_word_w = hit_control_w ? {24'h000000, control_q} :
                       hit_low_w     ? {24'h000000, value_low_q} :
                       hit_high_w    ? {24'h000000, value_high_q} :
                       hit_t3_w      ? {24'h000000, t3_control_q} :
                       hit_status_w  ? {29'h00000000, compare_latch_q,
                                        irq_enable_q, irq_flag_q} :
                       32'h00000000;

    // mode field classification
    assign mode_w             = control_q[CTL_MODE_LSB +: 4];
    assign capture_mode_w     = (mode_w[3:2] == 2'b01);
    assign compare_mode_w     = (mode_w == MODE_CMP_TOG)  | (mode_w == MODE_CMP_HIGH) |
                                (mode_w == MODE_CMP_LOW)  | (mode_w == MODE_CMP_SOFT) |
                                (mode_w == MODE_CMP_EVENT);
    assign compare_pin_mode_w = (mode_w == MODE_CMP_TOG)  | (mode_w == MODE_CMP_HIGH) |
                                (mode_w == MODE_CMP_LOW);
    assign event_mode_w       = (mode_w == MODE_CMP_EVENT);

    // timer assignment from the third timer control bits
    assign assign_w    = {t3_control_q[T3_ASSIGN_UPPER], t3_control_q[T3_ASSIGN_LOWER]};
    assign use_first_w = (assign_w == 2'b00) ? 1'b1 :
                         (assign_w == 2'b01) ? (CHANNEL_INDEX == 1) :
                         (assign_w == 2'b10) ? (CHANNEL_INDEX <= 2) :
                         1'b0;
    assign timer_w      = use_first_w ? first_time_base : second_time_base;
    assign timer_sync_w = use_first_w ? first_timer_sync_ok : second_timer_sync_ok;

    // pin edge detection and prescaling
    capture_edge_prescaler u_presc (
        .ref_clk       (ref_clk),
        .rst           (rst),
        .pin_level     (channel_pin_in),
        .mode          (mode_w),
        .capture_pulse (capture_pulse_w)
    );

    // capture happens only on a synchronous time base
    assign capture_w = capture_pulse_w & capture_mode_w & timer_sync_w;

    // compare: one match per arrival at equality
    assign value_w = {value_high_q, value_low_q};
    assign equal_w = (value_w == timer_w);
    assign match_w = compare_mode_w & timer_sync_w & equal_w & ~match_prev_q;
    assign event_w = match_w & event_mode_w;

    // flag: set by hardware, cleared by writing one; set wins
    assign flag_set_w = capture_w | match_w;
    assign flag_clr_w = wr_w & hit_status_w & pwdata[STS_FLAG];
    assign irq_flag_d = flag_set_w ? 1'b1 :
                        flag_clr_w ? 1'b0 : irq_flag_q;
    assign irq_enable_d = (wr_w & hit_status_w) ? pwdata[STS_ENABLE] : irq_enable_q;

    // control and timer control writes
    assign control_d    = (wr_w & hit_control_w) ? (pwdata[7:0] & CTL_WR_MASK) : control_q;
    assign t3_control_d = (wr_w & hit_t3_w) ? pwdata[7:0] : t3_control_q;

    // value pair: hardware capture overrides a same-cycle write
    assign value_low_d  = capture_w ? timer_w[7:0] :
                          (wr_w & hit_low_w) ? pwdata[7:0] : value_low_q;
    assign value_high_d = capture_w ? timer_w[15:8] :
                          (wr_w & hit_high_w) ? pwdata[7:0] : value_high_q;

    // compare output latch: presets on mode load, action on match
    always_comb begin
        compare_latch_d = compare_latch_q;
        if (mode_w == MODE_OFF) begin
            compare_latch_d = 1'b0;
        end else if (match_w && mode_w == MODE_CMP_TOG) begin
            compare_latch_d = ~compare_latch_q;
        end else if (match_w && mode_w == MODE_CMP_HIGH) begin
            compare_latch_d = 1'b1;
        end else if (match_w && mode_w == MODE_CMP_LOW) begin
            compare_latch_d = 1'b0;
        end
        if (wr_w && hit_control_w) begin
            if (pwdata[3:0] == MODE_CMP_HIGH) begin
                compare_latch_d = 1'b0;
            end else if (pwdata[3:0] == MODE_CMP_LOW) begin
                compare_latch_d = 1'b1;
            end else if (pwdata[3:0] == MODE_OFF) begin
                compare_latch_d = 1'b0;
            end
        end
    end

    // pin value: compare latch in pin modes, else port latch
    assign pin_next_w = compare_pin_mode_w ? compare_latch_d : port_latch_in;

    // register file
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            control_q    <= RST_CONTROL;
            value_low_q  <= RST_VALUE;
            value_high_q <= RST_VALUE;
            t3_control_q <= RST_T3_CONTROL;
            irq_flag_q   <= 1'b0;
            irq_enable_q <= 1'b0;
        end else begin
            control_q    <= control_d;
            value_low_q  <= value_low_d;
            value_high_q <= value_high_d;
            t3_control_q <= t3_control_d;
            irq_flag_q   <= irq_flag_d;
            irq_enable_q <= irq_enable_d;
        end
    end

    // compare state
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            compare_latch_q <= 1'b0;
            match_prev_q    <= 1'b0;
        end else begin
            compare_latch_q <= compare_latch_d;
            match_prev_q    <= equal_w & compare_mode_w;
        end
    end

    // pin and trigger outputs, registered
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            channel_pin_out       <= 1'b0;
            compare_owns_pin      <= 1'b0;
            special_event_trigger <= 1'b0;
            first_timer_reset     <= 1'b0;
            second_timer_reset    <= 1'b0;
            adc_start             <= 1'b0;
        end else begin
            channel_pin_out       <= pin_next_w;
            compare_owns_pin      <= compare_pin_mode_w;
            special_event_trigger <= event_w;
            first_timer_reset     <= event_w & use_first_w;
            second_timer_reset    <= event_w & ~use_first_w;
            adc_start             <= event_w & (CHANNEL_INDEX == 2) & adc_enabled;
        end
    end

    // interrupt request and timer control mirror
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            channel_irq_request <= 1'b0;
            third_timer_control <= RST_T3_CONTROL;
        end else begin
            channel_irq_request <= irq_flag_d & irq_enable_d;
            third_timer_control <= t3_control_d;
        end
    end

    // read data and error latched in the setup phase
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (setup_w) begin
            prdata  <= pwrite ? 32'h00000000 : rd_word_w;
            pslverr <= ~mapped_w;
        end
    end

endmodule : capture_compare_unit

`default_nettype wire

// ===== dv/ccu_checker.sv
// Purpose: port-level checks of the capture/compare channel
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound to the top module below
`timescale 1ns/1ns
`default_nettype none

module ccu_checker #(
    parameter int CHANNEL_INDEX = 4
)
(
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pwrite,
    input wire logic       first_timer_sync_ok,
    input wire logic       second_timer_sync_ok,
    input wire logic       first_timer_reset,
    input wire logic       second_timer_reset,
    input wire logic [7:0] third_timer_control,
    input wire logic       port_latch_in,
    input wire logic       channel_pin_out,
    input wire logic       compare_owns_pin,
    input wire logic       adc_enabled,
    input wire logic       special_event_trigger,
    input wire logic       adc_start,
    input wire logic       channel_irq_request
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // write strobe and the time base picked by the assignment bits
    logic       wr_now;
    logic       use_first;
    logic [1:0] pick;
    assign wr_now = psel && penable && pwrite;
    assign pick = {third_timer_control[6], third_timer_control[3]};
    assign use_first = (pick == 2'b00) || (pick == 2'b01 && CHANNEL_INDEX == 1)
                     || (pick == 2'b10 && CHANNEL_INDEX <= 2);

    property p_trig_pulse;
        special_event_trigger |=> !special_event_trigger;
    endproperty
    a_trig_pulse: assert property (p_trig_pulse) else $error("trigger too long");

    property p_trig_clears;
        special_event_trigger |-> first_timer_reset || second_timer_reset;
    endproperty
    a_trig_clears: assert property (p_trig_clears) else $error("no timer clear");

    property p_timer_pick;
        first_timer_reset || second_timer_reset
            |-> first_timer_reset == use_first && second_timer_reset != use_first;
    endproperty
    a_timer_pick: assert property (p_timer_pick) else $error("wrong timer cleared");

    property p_adc_start;
        special_event_trigger |-> adc_start == (CHANNEL_INDEX == 2 && $past(adc_enabled));
    endproperty
    a_adc_start: assert property (p_adc_start) else $error("conversion start wrong");

    property p_port_follow;
        !compare_owns_pin && !$past(compare_owns_pin) && !$past(rst)
            |-> channel_pin_out == $past(port_latch_in);
    endproperty
    a_port_follow: assert property (p_port_follow) else $error("pin not port latch");

    property p_flag_holds;
        channel_irq_request && !wr_now && !$past(wr_now) |=> channel_irq_request;
    endproperty
    a_flag_holds: assert property (p_flag_holds) else $error("request dropped");

    property p_trig_sync;
        special_event_trigger |-> $past(first_timer_sync_ok) || $past(second_timer_sync_ok);
    endproperty
    a_trig_sync: assert property (p_trig_sync) else $error("match on async timer");

    property p_owner_by_write;
        $rose(compare_owns_pin) |-> $past(wr_now, 1) || $past(wr_now, 2);
    endproperty
    a_owner_by_write: assert property (p_owner_by_write) else $error("pin taken");
endmodule : ccu_checker

bind capture_compare_unit ccu_checker #(.CHANNEL_INDEX(CHANNEL_INDEX)) u_ccu_checker (
    .ref_clk, .rst, .psel, .penable, .pwrite, .first_timer_sync_ok,
    .second_timer_sync_ok, .first_timer_reset, .second_timer_reset,
    .third_timer_control, .port_latch_in, .channel_pin_out, .compare_owns_pin,
    .adc_enabled, .special_event_trigger, .adc_start, .channel_irq_request
);

`default_nettype wire

// ===== dv/timer_base_model.sv
// Purpose: the two time bases feeding the channel
// Assumes: run low parks both counts at a known value
// Notes:   the second count parks at the inverse so the two differ
`timescale 1ns/1ns
`default_nettype none

module timer_base_model (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        run,
    input  wire logic [15:0] load_value,
    input  wire logic        first_timer_reset,
    input  wire logic        second_timer_reset,
    output var  logic [15:0] first_time_base,
    output var  logic [15:0] second_time_base
);
    // park while stopped, clear on the channel trigger, else count up
    always_ff @(posedge ref_clk) begin
        if (rst || !run) begin
            first_time_base  <= load_value;
            second_time_base <= ~load_value;
        end else begin
            first_time_base  <= first_timer_reset ? 16'h0000 : first_time_base + 16'h0001;
            second_time_base <= second_timer_reset ? 16'h0000 : second_time_base + 16'h0001;
        end
    end
endmodule : timer_base_model

`default_nettype wire

// ===== dv/capture_compare_unit_bench.sv
// Purpose: self-checking bench of the capture/compare channel
// Assumes: channel index 2; timers parked by the model for captures
// Notes:   apb requests change right after rising edges
`timescale 1ns/1ns
`default_nettype none

module capture_compare_unit_bench
    import ccu_pkg::*;
;

    logic        ref_clk = 1'b0;
    logic        rst     = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic        sync1   = 1'b1;
    logic        pin     = 1'b0;
    logic        latch   = 1'b0;
    logic        adc_en  = 1'b1;
    logic        run     = 1'b0;
    logic [15:0] load    = 16'h0000;
    logic [31:0] prdata;
    logic [15:0] tb1, tb2;
    logic [7:0]  t3;
    logic        pready, pslverr, t1r, t2r, sev, adc, pout, owns, irq;
    int          num_errors = 0;
    int          num_checks = 0;
    int          trig_n = 0;
    int          adc_n = 0;
    logic [3:0]  cap_mode [4] = '{MODE_CAP_FALL, MODE_CAP_RISE, MODE_CAP_RISE4, MODE_CAP_RISE16};
    int          cap_n [4] = '{1, 1, 4, 16};
    logic [3:0]  cmp_mode [6] = '{MODE_CMP_HIGH, MODE_CMP_LOW, MODE_CMP_TOG, MODE_CMP_SOFT,
                                  MODE_CMP_EVENT, MODE_CMP_EVENT};
    // last pass repeats the trigger mode with the converter disabled
    logic [5:0]  pre_pin = 6'h3a, post_pin = 6'h3d, own_exp = 6'h07, trig_exp = 6'h30;
    logic [5:0]  adc_exp = 6'h10;

    always #4 ref_clk = ~ref_clk;

    // count trigger and conversion pulses
    always @(posedge ref_clk) begin
        trig_n <= trig_n + int'(sev === 1'b1);
        adc_n <= adc_n + int'(adc === 1'b1);
    end

    capture_compare_unit #(.CHANNEL_INDEX(2)) u_capture_compare_unit (
        .ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .first_time_base(tb1), .second_time_base(tb2),
        .first_timer_sync_ok(sync1), .second_timer_sync_ok(1'b1),
        .first_timer_reset(t1r), .second_timer_reset(t2r), .third_timer_control(t3),
        .channel_pin_in(pin), .port_latch_in(latch), .channel_pin_out(pout),
        .compare_owns_pin(owns), .adc_enabled(adc_en), .special_event_trigger(sev),
        .adc_start(adc), .channel_irq_request(irq)
    );

    timer_base_model u_timer_base_model (
        .ref_clk, .rst, .run, .load_value(load), .first_timer_reset(t1r),
        .second_timer_reset(t2r), .first_time_base(tb1), .second_time_base(tb2)
    );

    // compare one value and count the outcome
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // print the counts and the verdict, then stop
    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out

    // one apb transfer: setup, then access until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            chk("apb answer", 32'h1, {31'h0, pready});
            close_out();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk("read data", exp, r);
        chk("slave error", {31'h0, err}, {31'h0, e});
    endtask : rd

    // one high pulse on the pin, long enough for capture to land
    task automatic pulse();
        pin <= 1'b1;
        repeat (6) @(posedge ref_clk);
        pin <= 1'b0;
        repeat (6) @(posedge ref_clk);
    endtask : pulse

    // main sequence
    initial begin
        logic [15:0] ev;
        int          t0;
        int          a0;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        for (int a = 0; a <= 16; a += 4) begin
            rd(8'(a), 32'h0, 1'b0);
        end
        rd(8'h14, 32'h0, 1'b1);
        wr(OFS_CONTROL, 32'hff);
        rd(OFS_CONTROL, 32'h3f, 1'b0);
        for (int i = 0; i < 4; i++) begin
            ev = 16'h1234 + 16'(i * 16'h1111);
            load <= ev;
            wr(OFS_CONTROL, 32'h0);
            wr(OFS_CONTROL, {28'h0, cap_mode[i]});
            wr(OFS_STATUS, 32'h1);
            repeat (cap_n[i] - 1) pulse();
            rd(OFS_STATUS, 32'h0, 1'b0);
            pulse();
            rd(OFS_STATUS, 32'h1, 1'b0);
            rd(OFS_VALUE_LOW, {24'h0, ev[7:0]}, 1'b0);
            rd(OFS_VALUE_HIGH, {24'h0, ev[15:8]}, 1'b0);
        end
        wr(OFS_CONTROL, 32'h0);
        wr(OFS_CONTROL, {28'h0, MODE_CAP_RISE});
        sync1 <= 1'b0;
        wr(OFS_STATUS, 32'h1);
        pulse();
        rd(OFS_STATUS, 32'h0, 1'b0);
        sync1 <= 1'b1;
        load <= 16'h5a0f;
        wr(OFS_T3_CONTROL, 32'h08);
        chk("timer control mirror", 32'h08, {24'h0, t3});
        pulse();
        rd(OFS_VALUE_LOW, 32'hf0, 1'b0);
        rd(OFS_VALUE_HIGH, 32'ha5, 1'b0);
        wr(OFS_T3_CONTROL, 32'h0);
        load <= 16'h0000;
        latch <= 1'b1;
        wr(OFS_VALUE_LOW, 32'h20);
        wr(OFS_VALUE_HIGH, 32'h0);
        for (int i = 0; i < 6; i++) begin
            wr(OFS_CONTROL, 32'h0);
            wr(OFS_STATUS, 32'h3);
            wr(OFS_CONTROL, {28'h0, cmp_mode[i]});
            repeat (2) @(posedge ref_clk);
            chk("pin preset", {31'h0, pre_pin[i]}, {31'h0, pout});
            chk("pin owner", {31'h0, own_exp[i]}, {31'h0, owns});
            t0 = trig_n;
            a0 = adc_n;
            adc_en <= (i != 5);
            run <= 1'b1;
            repeat (80) @(posedge ref_clk);
            run <= 1'b0;
            chk("irq request", 32'h1, {31'h0, irq});
            chk("pin after match", {31'h0, post_pin[i]}, {31'h0, pout});
            chk("periodic trigger", {31'h0, trig_exp[i]}, 32'(trig_n - t0 >= 2));
            chk("conversion start", {31'h0, adc_exp[i]}, 32'(adc_n - a0 >= 2));
            wr(OFS_STATUS, 32'h3);
            wr(OFS_CONTROL, 32'h0);
            rd(OFS_STATUS, 32'h2, 1'b0);
            chk("irq cleared", 32'h0, {31'h0, irq});
        end
        close_out();
    end
endmodule : capture_compare_unit_bench

`default_nettype wire
